/* logic/gptc_pkg.sv */
// gptc_pkg: constants and types of the general-purpose timer/counter
package gptc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PRE_W  = 8;
  localparam int unsigned CFG_W  = 3;
  localparam int unsigned IRQ_W  = 10;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CFG    = 8'h00;
  localparam logic [7:0] OFF_MODE_A = 8'h04;
  localparam logic [7:0] OFF_MODE_B = 8'h08;
  localparam logic [7:0] OFF_CTL    = 8'h0C;
  localparam logic [7:0] OFF_IMR    = 8'h10;
  localparam logic [7:0] OFF_RIS    = 8'h14;
  localparam logic [7:0] OFF_MIS    = 8'h18;
  localparam logic [7:0] OFF_ICR    = 8'h1C;
  localparam logic [7:0] OFF_ILR_A  = 8'h20;
  localparam logic [7:0] OFF_ILR_B  = 8'h24;
  localparam logic [7:0] OFF_MAT_A  = 8'h28;
  localparam logic [7:0] OFF_MAT_B  = 8'h2C;
  localparam logic [7:0] OFF_PR_A   = 8'h30;
  localparam logic [7:0] OFF_PR_B   = 8'h34;
  localparam logic [7:0] OFF_VAL_A  = 8'h38;
  localparam logic [7:0] OFF_VAL_B  = 8'h3C;

  // ---------------------------------------------------------------
  // field layouts and values
  // ---------------------------------------------------------------
  localparam logic [2:0] CFG_32    = 3'h0;
  localparam logic [2:0] CFG_RTC   = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam int unsigned CTL_A_LSB   = 0;
  localparam int unsigned CTL_RTC_BIT = 4;
  localparam int unsigned CTL_B_LSB   = 8;
  localparam int unsigned CTL_CC_W    = 4;
  localparam int unsigned MODE_W      = 3;
  localparam int unsigned IRQ_TO      = 0;
  localparam int unsigned IRQ_MATCH   = 1;
  localparam int unsigned IRQ_RTC     = 3;
  localparam int unsigned IRQ_B_LSB   = 8;
  localparam logic [9:0]  IRQ_VALID   = 10'h30B;
  localparam logic [15:0] CNT_RST     = 16'hFFFF;
  localparam logic [7:0]  PRE_RST     = 8'h00;
  localparam logic [31:0] RTC_FIRST   = 32'h0000_0001;
  localparam int unsigned RTC_IN_HZ   = 32768;
  localparam int unsigned RTC_OUT_HZ  = 1;

  typedef enum logic [1:0] {
    GPTC_MODE_NONE     = 2'b00,
    GPTC_MODE_ONESHOT  = 2'b01,
    GPTC_MODE_PERIODIC = 2'b10,
    GPTC_MODE_CAPTURE  = 2'b11
  } gptc_mode_t;

  typedef enum logic [1:0] {
    GPTC_EV_RISE = 2'b00,
    GPTC_EV_FALL = 2'b01,
    GPTC_EV_BOTH = 2'b11
  } gptc_event_t;

  typedef struct packed {
    logic       cap;
    gptc_mode_t mode;
  } gptc_mode_reg_t;

  typedef struct packed {
    gptc_event_t evt;
    logic        stall;
    logic        en;
  } gptc_cnt_ctl_t;

endpackage : gptc_pkg

/* logic/gptc_top.sv */
// gptc_top: two 16-bit counters, joined 32-bit timer and rtc, apb slave
// Notes on behaviour
// - config 0 joins counters as 32-bit timer, config 1 as 32-bit rtc.
// - joined mode: A load write fills B upper half; A read returns B:A.
// - joined timer is one 32-bit down-counter; only A mode field matters.
// - joined timer counts down, reloads after zero; one-shot stops, clears enable.
// - joined zero sets sticky A time-out flag; masked copy when unmasked.
// - writing load value while running reloads the counter next cycle.
// - stall bit freezes the timer or rtc during debug halt; edge count ignores it.
// - first selection of rtc mode loads the counter with one.
// - even pin carries 32.768 kHz, divided to 1 Hz rtc increments.
// - rtc count equal to A match rolls to zero and keeps counting.
// - rtc match sets raw flag, masked flag and interrupt; clear bit clears.
// - rtc stall-allow bit overrides both stall bits in rtc mode.
// - config 4 gives two identical independent 16-bit counters.
// - 16-bit timer is a down-counter with an 8-bit prescaler.
// - 16-bit timer reloads load and prescale after zero; one-shot stops.
// - 16-bit zero sets sticky time-out flag, masked flag and interrupt.
// - prescale P stretches each count step to P+1 clocks.
// - edge count mode with capture bit clear, edge chosen by event field.
// - each selected edge decrements by one; equal to match sets flags.
// - after edge match, reload, clear enable, ignore edges until re-enabled.
// - reset clears control; counters and loads 0xFFFF, prescales zero.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module gptc_top
  import gptc_pkg::*;
#(
  parameter int unsigned RTC_DIV = RTC_IN_HZ / RTC_OUT_HZ
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  // debug
  input  wire logic              dbg_halt,
  // capture pins
  input  wire logic              ccp_even_in,
  input  wire logic              ccp_odd_in,
  // interrupt
  output logic                   ctrl_irq
);

  localparam int unsigned DIV_W = $clog2(RTC_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIV - 1);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CFG_W-1:0]   cfg;
  logic               rtc_allow;
  logic               rtc_seen;
  logic [IRQ_W-1:0]   imr;
  logic [IRQ_W-1:0]   ris;
  logic [DIV_W-1:0]   div_cnt;
  gptc_mode_reg_t     mreg      [2];
  gptc_cnt_ctl_t      cctl      [2];
  logic [CNT_W-1:0]   ilr       [2];
  logic [CNT_W-1:0]   mat       [2];
  logic [CNT_W-1:0]   cnt       [2];
  logic [PRE_W-1:0]   pr        [2];
  logic [PRE_W-1:0]   pcnt      [2];
  logic               pslverr_q;

  logic [CNT_W-1:0]   next_ilr  [2];
  logic [CNT_W-1:0]   next_mat  [2];
  logic [CNT_W-1:0]   next_cnt  [2];
  logic [PRE_W-1:0]   next_pcnt [2];
  gptc_cnt_ctl_t      next_cc   [2];
  logic [1:0]         next_en;
  logic [DIV_W-1:0]   next_div;
  logic [IRQ_W-1:0]   next_ris;
  logic [1:0]         ev_to;
  logic [1:0]         ev_mt;
  logic               ev_rtc;
  logic               rtc_tick;
  logic [IRQ_W-1:0]   ev_vec;
  logic [31:0]        c32;
  logic [31:0]        n32;
  logic [DATA_W-1:0]  rd_val;
  logic               rd_err;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire setup   = psel & ~penable;
  wire wr_cfg  = wr & hit(paddr, OFF_CFG);
  wire wr_ctl  = wr & hit(paddr, OFF_CTL);
  wire wr_imr  = wr & hit(paddr, OFF_IMR);
  wire wr_icr  = wr & hit(paddr, OFF_ICR);
  wire [1:0] wr_mode = {wr & hit(paddr, OFF_MODE_B), wr & hit(paddr, OFF_MODE_A)};
  wire [1:0] wr_ilr  = {wr & hit(paddr, OFF_ILR_B), wr & hit(paddr, OFF_ILR_A)};
  wire [1:0] wr_mat  = {wr & hit(paddr, OFF_MAT_B), wr & hit(paddr, OFF_MAT_A)};
  wire [1:0] wr_pr   = {wr & hit(paddr, OFF_PR_B), wr & hit(paddr, OFF_PR_A)};

  wire rtc_md = (cfg == CFG_RTC);
  wire j32    = (cfg == CFG_32) | rtc_md;
  wire split  = (cfg == CFG_SPLIT);
  wire rtc_first = wr_cfg & (pwdata[CFG_W-1:0] == CFG_RTC) & ~rtc_seen;
  wire [IRQ_W-1:0] clr_vec = wr_icr ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] mis = ris & imr;
  wire [31:0] l32 = {ilr[1], ilr[0]};
  wire [31:0] m32 = {mat[1], mat[0]};
  wire stall_rtc = dbg_halt & (cctl[0].stall | cctl[1].stall) & ~rtc_allow;

  // ---------------------------------------------------------------
  // pin synchronisers and per-counter wiring
  // ---------------------------------------------------------------
  wire  [1:0] pin_raw = {ccp_odd_in, ccp_even_in};
  logic [2:0] sync_q [2];
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic [1:0] edge_hit;
  logic [1:0] stall;

  for (genvar g = 0; g < 2; g++) begin : g_cnt
    localparam int unsigned CLSB = (g == 0) ? CTL_A_LSB : CTL_B_LSB;
    // stage 0 feeds stage 1 only; levels count once stages 1 and 2 agree
    wire settled = (sync_q[g][1] == sync_q[g][2]);
    assign pin_rise[g] = settled & sync_q[g][2] & ~pin_lvl[g];
    assign pin_fall[g] = settled & ~sync_q[g][2] & pin_lvl[g];
    assign stall[g] = dbg_halt & cctl[g].stall & ~(rtc_md & rtc_allow);

    always_comb begin
      unique case (cctl[g].evt)
        GPTC_EV_RISE: edge_hit[g] = pin_rise[g];
        GPTC_EV_FALL: edge_hit[g] = pin_fall[g];
        GPTC_EV_BOTH: edge_hit[g] = pin_rise[g] | pin_fall[g];
        default:      edge_hit[g] = pin_rise[g];
      endcase
    end

    if (g == 0) begin : g_lo
      assign next_ilr[g] = wr_ilr[0] ? pwdata[CNT_W-1:0] : ilr[g];
      assign next_mat[g] = wr_mat[0] ? pwdata[CNT_W-1:0] : mat[g];
    end else begin : g_hi
      // joined modes route the upper half of an A write into B
      wire ilr_up = j32 & wr_ilr[0] & ~wr_ilr[1];
      wire mat_up = j32 & wr_mat[0] & ~wr_mat[1];
      assign next_ilr[g] = ilr_up ? pwdata[DATA_W-1:CNT_W] :
                           wr_ilr[1] ? pwdata[CNT_W-1:0] : ilr[g];
      assign next_mat[g] = mat_up ? pwdata[DATA_W-1:CNT_W] :
                           wr_mat[1] ? pwdata[CNT_W-1:0] : mat[g];
    end

    assign next_cc[g] = wr_ctl ? gptc_cnt_ctl_t'(pwdata[CLSB +: CTL_CC_W]) :
                        gptc_cnt_ctl_t'{evt: cctl[g].evt, stall: cctl[g].stall,
                                        en: next_en[g]};

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync_q[g]  <= '0;
        pin_lvl[g] <= 1'b0;
      end else begin
        sync_q[g]  <= {sync_q[g][1:0], pin_raw[g]};
        pin_lvl[g] <= settled ? sync_q[g][2] : pin_lvl[g];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ilr[g]  <= CNT_RST;
        cnt[g]  <= CNT_RST;
        mat[g]  <= '0;
        pr[g]   <= PRE_RST;
        pcnt[g] <= PRE_RST;
        mreg[g] <= '0;
        cctl[g] <= '0;
      end else begin
        ilr[g]  <= next_ilr[g];
        mat[g]  <= next_mat[g];
        cnt[g]  <= next_cnt[g];
        pcnt[g] <= next_pcnt[g];
        cctl[g] <= next_cc[g];
        if (wr_pr[g])
          pr[g] <= pwdata[PRE_W-1:0];
        if (wr_mode[g])
          mreg[g] <= gptc_mode_reg_t'(pwdata[MODE_W-1:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // counting
  // ---------------------------------------------------------------
  always_comb begin
    c32      = {cnt[1], cnt[0]};
    n32      = c32;
    ev_rtc   = 1'b0;
    rtc_tick = 1'b0;
    next_div = '0;
    ev_vec   = '0;
    for (int n = 0; n < 2; n++) begin
      next_cnt[n]  = cnt[n];
      next_pcnt[n] = pcnt[n];
      next_en[n]   = cctl[n].en;
      ev_to[n]     = 1'b0;
      ev_mt[n]     = 1'b0;
    end
    if (rtc_md) begin
      if (cctl[0].en) begin
        next_div = div_cnt;
        if (pin_rise[0] && !stall_rtc) begin
          if (div_cnt == DIV_LAST) begin
            next_div = '0;
            rtc_tick = 1'b1;
          end else begin
            next_div = div_cnt + 1'b1;
          end
        end
      end
      if (rtc_tick) begin
        if (c32 == m32) begin
          n32    = '0;
          ev_rtc = 1'b1;
        end else begin
          n32 = c32 + 1'b1;
        end
      end
    end else if (j32) begin
      // only the A mode field picks one-shot or periodic
      if (cctl[0].en && !stall[0]) begin
        if (c32 == '0) begin
          n32      = l32;
          ev_to[0] = 1'b1;
          if (mreg[0].mode == GPTC_MODE_ONESHOT)
            next_en[0] = 1'b0;
        end else begin
          n32 = c32 - 1'b1;
        end
      end
      if (wr_ilr != '0)
        n32 = {next_ilr[1], next_ilr[0]};
    end
    if (j32) begin
      next_cnt[1] = n32[DATA_W-1:CNT_W];
      next_cnt[0] = n32[CNT_W-1:0];
    end else if (split) begin
      for (int n = 0; n < 2; n++) begin
        unique case (mreg[n].mode)
          GPTC_MODE_CAPTURE: begin
            if (!mreg[n].cap && cctl[n].en && edge_hit[n]) begin
              if ((cnt[n] - 1'b1) == mat[n]) begin
                next_cnt[n] = ilr[n];
                next_en[n]  = 1'b0;
                ev_mt[n]    = 1'b1;
              end else begin
                next_cnt[n] = cnt[n] - 1'b1;
              end
            end
            // edge count starts from the load value
            if (wr_ilr[n])
              next_cnt[n] = next_ilr[n];
          end
          GPTC_MODE_ONESHOT, GPTC_MODE_PERIODIC: begin
            if (cctl[n].en && !stall[n]) begin
              if (pcnt[n] != '0) begin
                next_pcnt[n] = pcnt[n] - 1'b1;
              end else begin
                next_pcnt[n] = pr[n];
                if (cnt[n] == '0) begin
                  next_cnt[n] = ilr[n];
                  ev_to[n]    = 1'b1;
                  if (mreg[n].mode == GPTC_MODE_ONESHOT)
                    next_en[n] = 1'b0;
                end else begin
                  next_cnt[n] = cnt[n] - 1'b1;
                end
              end
            end
            if (wr_ilr[n])
              next_cnt[n] = next_ilr[n];
          end
          GPTC_MODE_NONE: begin
          end
        endcase
      end
    end
    if (rtc_first) begin
      next_cnt[1] = RTC_FIRST[DATA_W-1:CNT_W];
      next_cnt[0] = RTC_FIRST[CNT_W-1:0];
    end
    ev_vec[IRQ_RTC] = ev_rtc;
    for (int n = 0; n < 2; n++) begin
      ev_vec[IRQ_TO + n * IRQ_B_LSB]    = ev_to[n];
      ev_vec[IRQ_MATCH + n * IRQ_B_LSB] = ev_mt[n];
    end
  end

  // raw flags: a new event beats a clear in the same cycle
  assign next_ris = ((ris & ~clr_vec) | ev_vec) & IRQ_VALID;
  assign ctrl_irq = |mis;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg       <= '0;
      rtc_allow <= 1'b0;
      rtc_seen  <= 1'b0;
      imr       <= '0;
      ris       <= '0;
      div_cnt   <= '0;
    end else begin
      ris     <= next_ris;
      div_cnt <= next_div;
      if (wr_cfg)
        cfg <= pwdata[CFG_W-1:0];
      if (rtc_first)
        rtc_seen <= 1'b1;
      if (wr_ctl)
        rtc_allow <= pwdata[CTL_RTC_BIT];
      if (wr_imr)
        imr <= pwdata[IRQ_W-1:0] & IRQ_VALID;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    case (paddr)
      OFF_CFG:    rd_val = DATA_W'(cfg);
      OFF_MODE_A: rd_val = DATA_W'(mreg[0]);
      OFF_MODE_B: rd_val = DATA_W'(mreg[1]);
      OFF_CTL:    rd_val = DATA_W'({cctl[1], 3'h0, rtc_allow, cctl[0]});
      OFF_IMR:    rd_val = DATA_W'(imr);
      OFF_RIS:    rd_val = DATA_W'(ris);
      OFF_MIS:    rd_val = DATA_W'(mis);
      OFF_ICR:    rd_val = '0;
      OFF_ILR_A:  rd_val = j32 ? l32 : DATA_W'(ilr[0]);
      OFF_ILR_B:  rd_val = DATA_W'(ilr[1]);
      OFF_MAT_A:  rd_val = j32 ? m32 : DATA_W'(mat[0]);
      OFF_MAT_B:  rd_val = DATA_W'(mat[1]);
      OFF_PR_A:   rd_val = DATA_W'(pr[0]);
      OFF_PR_B:   rd_val = DATA_W'(pr[1]);
      OFF_VAL_A:  rd_val = j32 ? c32 : DATA_W'(cnt[0]);
      OFF_VAL_B:  rd_val = DATA_W'(cnt[1]);
      default:    rd_err = 1'b1;
    endcase
  end

  // snapshot taken in the setup cycle, answered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata    <= rd_val;
      pslverr_q <= rd_err;
    end
  end

  assign pready  = acc;
  assign pslverr = acc & pslverr_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] wdata_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wdata_d <= '0;
    else
      wdata_d <= pwdata;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rtc_first;
    rtc_first |=> ({cnt[1], cnt[0]} == RTC_FIRST);
  endproperty
  a_rtc_first: assert property (p_rtc_first) else $error("rtc first load wrong");

  property p_join_wr;
    (j32 && wr_ilr == 2'b01) |=> (ilr[1] == wdata_d[DATA_W-1:CNT_W]);
  endproperty
  a_join_wr: assert property (p_join_wr) else $error("upper half not in B load");

  property p_oneshot32;
    (j32 && !rtc_md && cctl[0].en && !stall[0] && c32 == '0 && !wr_ctl
     && wr_ilr == '0 && mreg[0].mode == GPTC_MODE_ONESHOT && !rtc_first)
    |=> (!cctl[0].en && {cnt[1], cnt[0]} == l32 && ris[IRQ_TO]);
  endproperty
  a_oneshot32: assert property (p_oneshot32) else $error("one-shot did not stop");

  property p_to_sticky;
    (ris[IRQ_TO] && !wr_icr) |=> ris[IRQ_TO];
  endproperty
  a_to_sticky: assert property (p_to_sticky) else $error("time-out flag dropped");

  property p_ilr_load;
    (split && wr_ilr[0] && mreg[0].mode != GPTC_MODE_CAPTURE
     && mreg[0].mode != GPTC_MODE_NONE) |=> (cnt[0] == wdata_d[CNT_W-1:0]);
  endproperty
  a_ilr_load: assert property (p_ilr_load) else $error("load write not taken");

  property p_stall;
    (!rtc_md && stall[0] && wr_ilr == '0 && !rtc_first
     && mreg[0].mode != GPTC_MODE_CAPTURE)
    |=> ($stable(cnt[0]) && $stable(pcnt[0]));
  endproperty
  a_stall: assert property (p_stall) else $error("counter moved in halt");

  property p_prescale;
    (split && mreg[0].mode == GPTC_MODE_PERIODIC && cctl[0].en && !stall[0]
     && pcnt[0] == '0 && cnt[0] != '0 && !wr_ilr[0] && !wr_pr[0])
    |=> (cnt[0] == $past(cnt[0]) - 1'b1 && pcnt[0] == pr[0]);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale step wrong");

  property p_edge_match;
    ev_mt[1] |=> (!cctl[1].en || $past(wr_ctl)) && ris[IRQ_B_LSB + IRQ_MATCH];
  endproperty
  a_edge_match: assert property (p_edge_match) else $error("edge match not done");

  property p_rtc_roll;
    (rtc_tick && c32 == m32 && !rtc_first) |=> ({cnt[1], cnt[0]} == '0 && ris[IRQ_RTC]);
  endproperty
  a_rtc_roll: assert property (p_rtc_roll) else $error("rtc did not roll");

  property p_irq;
    (ev_rtc && imr[IRQ_RTC] && !wr_imr) |=> ctrl_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("rtc interrupt missing");

endmodule : gptc_top
`default_nettype wire

/* test/gptc_pin_model.sv */
// gptc_pin_model: external source that drives one capture pin
`timescale 1ns/1ps
`default_nettype none
module gptc_pin_model (
  // clock
  input  wire logic pclk,
  // capture pin
  output logic      pin
);
  initial pin = 1'b0;
  // ----------------------------------------------------------
  // level changes
  // ----------------------------------------------------------
  // three clocks per level keeps the rate below clk/4
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (3) @(posedge pclk);
      pin <= ~pin;
    end
  endtask : toggle
endmodule : gptc_pin_model
`default_nettype wire

/* test/gptc_top_tb.sv */
// gptc_top_tb: self-checking bench of the timer/counter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module gptc_top_tb;
  import gptc_pkg::*;
  logic              pclk     = 1'b0;
  logic              presetn  = 1'b0;
  logic              psel     = 1'b0;
  logic              penable  = 1'b0;
  logic              pwrite   = 1'b0;
  logic              dbg_halt = 1'b0;
  logic [ADDR_W-1:0] paddr    = '0;
  logic [DATA_W-1:0] pwdata   = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] v;
  logic              pready;
  logic              pslverr;
  logic              err;
  logic              ctrl_irq;
  logic              ccp_even_in;
  logic              ccp_odd_in;
  int                failures = 0;
  int                checked  = 0;
  int                seed     = 39;
  int                n;
  int                c;
  int                p;
  int                t0;
  int                cyc      = 0;

  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  gptc_top #(.RTC_DIV(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt),
    .ccp_even_in(ccp_even_in), .ccp_odd_in(ccp_odd_in), .ctrl_irq(ctrl_irq)
  );
  gptc_pin_model u_even (.pclk(pclk), .pin(ccp_even_in));
  gptc_pin_model u_odd  (.pclk(pclk), .pin(ccp_odd_in));

  // ----------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rdr

  task automatic wait_ris(input int b);
    int k;
    k = 0;
    do begin rdr(OFF_RIS); k++; end while (rd[b] !== 1'b1 && k < 200);
  endtask : wait_ris

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    end_of_test();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdr(OFF_ILR_A); `CHK("ilr_rst", 32'hFFFF_FFFF, rd)
    rdr(OFF_PR_A); `CHK("pr_rst", 32'h0000_0000, rd)
    rdr(OFF_CTL); `CHK("ctl_rst", 32'h0000_0000, rd)
    rdr(8'h40); `CHK("unmapped", 1'b1, err)
    $display("reset test done");
    // joined one-shot, B mode set to periodic to show it is ignored
    n = 24 + ($random(seed) & 15);
    wr(OFF_MODE_A, 32'h1);
    wr(OFF_MODE_B, 32'h2);
    wr(OFF_ILR_A, 32'hABCD_1234);
    rdr(OFF_ILR_B); `CHK("ilr_b_half", 32'h0000_ABCD, rd)
    wr(OFF_ILR_A, 32'(n));
    wr(OFF_IMR, 32'h1);
    wr(OFF_CTL, 32'h1);
    wait_ris(IRQ_TO); `CHK("a_timeout", 1'b1, rd[IRQ_TO])
    `CHK("irq_a", 1'b1, ctrl_irq)
    rdr(OFF_CTL); `CHK("a_en_clr", 1'b0, rd[0])
    rdr(OFF_VAL_A); `CHK("a_reload", 32'(n), rd)
    wr(OFF_ICR, 32'h1);
    rdr(OFF_RIS); `CHK("a_clear", 1'b0, rd[IRQ_TO])
    // debug stall
    wr(OFF_ILR_A, 32'd1000);
    wr(OFF_CTL, 32'h3);
    dbg_halt <= 1'b1;
    rdr(OFF_VAL_A);
    v = rd;
    repeat (10) @(posedge pclk);
    rdr(OFF_VAL_A); `CHK("stall_hold", v, rd)
    dbg_halt <= 1'b0;
    rdr(OFF_VAL_A); `CHK("stall_run", 1'b1, rd < v)
    wr(OFF_CTL, 32'h0);
    $display("joined timer test done");
    // split edge count on B, both edges, 6 edges sent, 4 counted
    wr(OFF_CFG, 32'h4);
    wr(OFF_MODE_B, 32'h3);
    wr(OFF_ILR_B, 32'd10);
    wr(OFF_MAT_B, 32'd6);
    wr(OFF_CTL, 32'h0000_0D00);
    u_odd.toggle(6);
    repeat (6) @(posedge pclk);
    rdr(OFF_RIS); `CHK("b_match", 1'b1, rd[IRQ_B_LSB+IRQ_MATCH])
    rdr(OFF_VAL_B); `CHK("b_reload", 32'd10, rd)
    rdr(OFF_CTL); `CHK("b_en_clr", 1'b0, rd[CTL_B_LSB])
    $display("edge count test done");
    // split periodic on A with prescaler, period taken between two time-outs
    p = 1 + ($random(seed) & 3);
    n = 3 + ($random(seed) & 7);
    wr(OFF_MODE_A, 32'h2);
    wr(OFF_PR_A, 32'(p));
    wr(OFF_ILR_A, 32'(n));
    rdr(OFF_VAL_A); `CHK("ilr_load16", 32'(n), rd)
    wr(OFF_CTL, 32'h1);
    do @(posedge pclk); while (ctrl_irq !== 1'b1);
    t0 = cyc;
    wr(OFF_ICR, 32'h1);
    do @(posedge pclk); while (ctrl_irq !== 1'b1);
    `CHK("period", (n + 1) * (p + 1), cyc - t0)
    rdr(OFF_CTL); `CHK("a_periodic_en", 1'b1, rd[0])
    rdr(OFF_VAL_B); `CHK("b_idle", 32'd10, rd)
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'h1);
    $display("split timer test done");
    // rtc, match 3, three 1 Hz ticks from the first load
    c = 1;
    repeat (3) c = (c == 3) ? 0 : c + 1;
    wr(OFF_CFG, 32'h1);
    rdr(OFF_VAL_A); `CHK("rtc_first", RTC_FIRST, rd)
    wr(OFF_MAT_A, 32'd3);
    wr(OFF_IMR, 32'h8);
    wr(OFF_CTL, 32'h13);
    dbg_halt <= 1'b1;
    u_even.toggle(24);
    dbg_halt <= 1'b0;
    repeat (6) @(posedge pclk);
    rdr(OFF_RIS); `CHK("rtc_match", 1'b1, rd[IRQ_RTC])
    `CHK("rtc_irq", 1'b1, ctrl_irq)
    rdr(OFF_VAL_A); `CHK("rtc_roll", 32'(c), rd)
    wr(OFF_ICR, 32'h8);
    rdr(OFF_MIS); `CHK("rtc_clear", 1'b0, rd[IRQ_RTC])
    $display("rtc test done");
    end_of_test();
  end
endmodule : gptc_top_tb
`default_nettype wire
